// ===== hdl/lcrcs_pkg.sv
package lcrcs_pkg;
   // ----------------------------------------
   // register offsets (byte addresses)
   // ----------------------------------------
   localparam logic [7:0] ADDR_CTRL   = 8'h00;
   localparam logic [7:0] ADDR_LUT0   = 8'h04;
   localparam logic [7:0] ADDR_LUT3   = 8'h10;
   localparam logic [7:0] ADDR_STATUS = 8'h14;

   // ----------------------------------------
   // control field positions
   // ----------------------------------------
   localparam int CTL_CSEL0  = 0;  // [1:0] cell 0 clock select
   localparam int CTL_POL0   = 2;  // cell 0 falling edge
   localparam int CTL_CSEL1  = 3;  // [4:3] cell 1 clock select
   localparam int CTL_POL1   = 5;  // cell 1 falling edge
   localparam int CTL_AINT   = 6;  // clock a from logic
   localparam int CTL_BINT   = 7;  // clock b from logic
   localparam int CTL_DSEL0  = 8;  // [9:8] cell 0 data source
   localparam int CTL_DSEL1  = 10; // [11:10] cell 1 data source
   localparam int CTL_BELOW  = 12; // [14:12] downward link source
   localparam int CTL_INV    = 15; // [18:15] second input invert
   localparam int CTL_CSRC   = 19; // [20:19] top input source
   localparam int CTL_WIDTH  = 21;
   localparam logic [CTL_WIDTH-1:0] CTRL_RST = 21'h00000;
   localparam logic [31:0]          LUT_RST  = 32'h00000000;

   // internal sources of the routed clocks
   localparam int ROUTED_GLOBAL_CLOCK_A_CELL = 1;
   localparam int ROUTED_GLOBAL_CLOCK_B_CELL = 3;

   // ----------------------------------------
   // enumerations
   // ----------------------------------------
   typedef enum logic [1:0] {
      CS_HARD = 2'b00,
      CS_A    = 2'b01,
      CS_B    = 2'b10,
      CS_OFF  = 2'b11
   } lcrcs_clksel_t;

   typedef enum logic [1:0] {
      DS_FIXED = 2'b00,
      DS_PAIR  = 2'b01,
      DS_OTHER = 2'b10,
      DS_ABOVE = 2'b11
   } lcrcs_dsel_t;

   typedef enum logic [1:0] {
      TS_PIN  = 2'b00,
      TS_ROUTED_GLOBAL_CLOCK_A = 2'b01,
      TS_ROUTED_GLOBAL_CLOCK_B = 2'b10,
      TS_RSVD = 2'b11
   } lcrcs_tsrc_t;
endpackage : lcrcs_pkg

// ===== hdl/lcrcs_reg_cell.sv
`timescale 1ns/10ps
`default_nettype none
module lcrcs_reg_cell (
   input  wire logic pclk,      // system clock
   input  wire logic presetn,   // async reset, low
   input  wire logic clk_lvl,   // selected clock network level
   input  wire logic fall_edge, // capture on falling edge
   input  wire logic d,         // data in
   input  wire logic sel0,      // enable select line 0
   input  wire logic sel1,      // enable select line 1
   input  wire logic clear_n,   // async clear, low
   input  wire logic preset_n,  // async preset, low
   output logic      q          // stored bit
);
   logic prev_q;
   logic evt;
   logic en;

   // ----------------------------------------
   // edge detect on the sampled clock net
   // ----------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prev_q <= 1'b0;
      end else begin
         prev_q <= clk_lvl;
      end
   end

   // polarity is private to this cell
   assign evt = fall_edge ? (prev_q & ~clk_lvl) : (~prev_q & clk_lvl);
   assign en  = sel0 | sel1;

   // clear beats preset; both act without the clock
   always_ff @(posedge pclk or negedge presetn or negedge clear_n or negedge preset_n) begin
      if (!presetn) begin
         q <= 1'b0;
      end else if (!clear_n) begin
         q <= 1'b0;
      end else if (!preset_n) begin
         q <= 1'b1;
      end else if (evt && en) begin
         q <= d;
      end
   end

   property p_clear;
      @(posedge pclk) disable iff (!presetn) !clear_n |-> !q;
   endproperty
   a_clear: assert property (p_clear) else $error("clear did not force low");

   property p_preset;
      @(posedge pclk) disable iff (!presetn) (clear_n && !preset_n) |-> q;
   endproperty
   a_preset: assert property (p_preset) else $error("preset did not force high");

   property p_hold;
      @(posedge pclk) disable iff (!presetn)
         (clear_n && preset_n && !sel0 && !sel1) ##1 (clear_n && preset_n) |-> $stable(q);
   endproperty
   a_hold: assert property (p_hold) else $error("disabled cell changed");

   property p_edge;
      @(posedge pclk) disable iff (!presetn)
         (fall_edge && $fell(clk_lvl) && en && clear_n && preset_n) |=>
         (!clear_n || !preset_n || q == $past(d));
   endproperty
   a_edge: assert property (p_edge) else $error("falling edge not captured");

   property p_persist;
      @(posedge pclk) disable iff (!presetn)
         ($rose(clear_n) && preset_n && !(evt && en)) ##1 (clear_n && preset_n) |-> !q;
   endproperty
   a_persist: assert property (p_persist) else $error("state lost after clear");
endmodule : lcrcs_reg_cell
`default_nettype wire

// ===== hdl/lcrcs_cluster_top.sv
// The APB interface to the registers and the placing of the registers were decided locally.
`timescale 1ns/10ps
`default_nettype none
module lcrcs_cluster_top
   import lcrcs_pkg::*;
(
   input  wire logic        pclk,                     // 250 MHz clock
   input  wire logic        presetn,                  // async reset, low
   input  wire logic [7:0]  paddr,                    // apb address
   input  wire logic        psel,                     // apb select
   input  wire logic        penable,                  // apb enable
   input  wire logic        pwrite,                   // apb write
   input  wire logic [31:0] pwdata,                   // apb write data
   output logic      [31:0] prdata,                   // apb read data
   output logic             pready,                   // apb ready
   output logic             pslverr,                  // apb error
   input  wire logic        hard_clock,               // dedicated clock net
   input  wire logic        routed_global_clock_a,    // clock a pin
   input  wire logic        routed_global_clock_b,    // clock b pin
   input  wire logic [15:0] comb_in,                  // four plain inputs per cell
   input  wire logic [3:0]  invertible_second_input,  // one per comb cell
   input  wire logic [1:0]  enable_select_line_0,     // per register cell
   input  wire logic [1:0]  enable_select_line_1,     // per register cell
   input  wire logic [1:0]  clear_n,                  // async clear, low
   input  wire logic [1:0]  preset_n,                 // async preset, low
   input  wire logic        link_from_above,          // fast link from group above
   output logic      [3:0]  comb_out,                 // comb cell outputs
   output logic      [1:0]  reg_q,                    // register cell outputs
   output logic             link_to_below             // fast link to group below
);
   logic [CTL_WIDTH-1:0] ctrl_q;
   logic [31:0]          lut_q [4];
   logic                 clk_a_lvl;
   logic                 clk_b_lvl;
   logic                 top_in;
   logic [1:0]           cell_clk;
   logic [1:0]           cell_d;
   logic [5:0]           cell_outs;
   logic                 wr_en;
   logic                 rd_setup;
   logic                 mapped;
   logic [31:0]          rd_d;
   lcrcs_tsrc_t          tsrc;

   // ----------------------------------------
   // apb slave
   // ----------------------------------------
   // zero wait states: the read word is captured in the setup cycle
   assign pready   = 1'b1;
   assign mapped   = (paddr[1:0] == 2'b00) && (paddr <= ADDR_STATUS);
   assign pslverr  = psel && penable && !mapped;
   assign wr_en    = psel && penable && pwrite && mapped;
   assign rd_setup = psel && !penable && !pwrite;

   // control register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_q <= CTRL_RST;
      end else if (wr_en && paddr == ADDR_CTRL) begin
         ctrl_q <= pwdata[CTL_WIDTH-1:0];
      end
   end

   // truth tables, one word per comb cell
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int i = 0; i < 4; i++) begin
            lut_q[i] <= LUT_RST;
         end
      end else if (wr_en && paddr >= ADDR_LUT0 && paddr <= ADDR_LUT3) begin
         lut_q[2'(paddr[4:2] - 3'd1)] <= pwdata;
      end
   end

   // read mux; status shows live fabric state
   always_comb begin
      rd_d = 32'h00000000;
      case (paddr)
         ADDR_CTRL:   rd_d[CTL_WIDTH-1:0] = ctrl_q;
         8'h04:       rd_d = lut_q[0];
         8'h08:       rd_d = lut_q[1];
         8'h0c:       rd_d = lut_q[2];
         ADDR_LUT3:   rd_d = lut_q[3];
         ADDR_STATUS: rd_d[8:0] = {clk_b_lvl, clk_a_lvl, hard_clock, comb_out, reg_q};
         default:     rd_d = 32'h00000000;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h00000000;
      end else if (rd_setup) begin
         prdata <= rd_d;
      end
   end

   // ----------------------------------------
   // routed clock nets
   // ----------------------------------------
   // exactly three nets: hard clock plus a and b
   // when logic sources a net the pin is ignored; the board holds it static
   assign clk_a_lvl = ctrl_q[CTL_AINT] ? comb_out[ROUTED_GLOBAL_CLOCK_A_CELL] : routed_global_clock_a;
   assign clk_b_lvl = ctrl_q[CTL_BINT] ? comb_out[ROUTED_GLOBAL_CLOCK_B_CELL] : routed_global_clock_b;

   // top table input may be a routed clock, never the hard clock
   assign tsrc = lcrcs_tsrc_t'(ctrl_q[CTL_CSRC+1:CTL_CSRC]);
   always_comb begin
      case (tsrc)
         TS_ROUTED_GLOBAL_CLOCK_A: top_in = clk_a_lvl;
         TS_ROUTED_GLOBAL_CLOCK_B: top_in = clk_b_lvl;
         default: top_in = 1'b0;
      endcase
   end

   // ----------------------------------------
   // combinatorial cells
   // ----------------------------------------
   // clock a/b sources come from cells 1 and 3; a loop through them is the user's problem
   for (genvar g = 0; g < 4; g++) begin : g_comb
      logic [4:0] idx;
      logic       in4;
      assign in4 = (tsrc == TS_ROUTED_GLOBAL_CLOCK_A || tsrc == TS_ROUTED_GLOBAL_CLOCK_B) ? top_in : comb_in[4*g+3];
      assign idx = {in4, comb_in[4*g+2], comb_in[4*g+1],
                    invertible_second_input[g] ^ ctrl_q[CTL_INV+g],
                    comb_in[4*g]};
      assign comb_out[g] = lut_q[g][idx];
   end

   // ----------------------------------------
   // register cells, one per cluster
   // ----------------------------------------
   // two identical clusters side by side, each two comb cells and one register
   for (genvar k = 0; k < 2; k++) begin : g_clu
      lcrcs_clksel_t csel;
      lcrcs_dsel_t   dsel;
      assign csel = lcrcs_clksel_t'(ctrl_q[CTL_CSEL0+3*k+1:CTL_CSEL0+3*k]);
      assign dsel = lcrcs_dsel_t'(ctrl_q[CTL_DSEL0+2*k+1:CTL_DSEL0+2*k]);

      // clock select mux; the off setting parks the net low
      always_comb begin
         case (csel)
            CS_HARD: cell_clk[k] = hard_clock;
            CS_A:    cell_clk[k] = clk_a_lvl;
            CS_B:    cell_clk[k] = clk_b_lvl;
            default: cell_clk[k] = 1'b0;
         endcase
      end

      // data source: fixed wire, or one fuse from a neighbour
      always_comb begin
         case (dsel)
            DS_FIXED: cell_d[k] = comb_out[2*k];
            DS_PAIR:  cell_d[k] = comb_out[2*k+1];
            DS_OTHER: cell_d[k] = comb_out[2-2*k];
            DS_ABOVE: cell_d[k] = link_from_above;
            default:  cell_d[k] = comb_out[2*k];
         endcase
      end

      lcrcs_reg_cell u_cell (
         .pclk      (pclk),
         .presetn   (presetn),
         .clk_lvl   (cell_clk[k]),
         .fall_edge (ctrl_q[CTL_POL0+3*k]),
         .d         (cell_d[k]),
         .sel0      (enable_select_line_0[k]),
         .sel1      (enable_select_line_1[k]),
         .clear_n   (clear_n[k]),
         .preset_n  (preset_n[k]),
         .q         (reg_q[k])
      );
   end

   // ----------------------------------------
   // downward fast link
   // ----------------------------------------
   // codes 6 and 7 park the link low
   assign cell_outs = {reg_q, comb_out};
   always_comb begin
      case (ctrl_q[CTL_BELOW+2:CTL_BELOW])
         3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h5:
            link_to_below = cell_outs[ctrl_q[CTL_BELOW+2:CTL_BELOW]];
         default:
            link_to_below = 1'b0;
      endcase
   end

   // ----------------------------------------
   // checks
   // ----------------------------------------
   property p_fixed_link;
      @(posedge pclk) disable iff (!presetn)
         (ctrl_q[CTL_DSEL0+1:CTL_DSEL0] == 2'b00) |-> g_clu[0].u_cell.d == comb_out[0];
   endproperty
   a_fixed_link: assert property (p_fixed_link) else $error("fixed link broken");

   property p_above;
      @(posedge pclk) disable iff (!presetn)
         (ctrl_q[CTL_DSEL1+1:CTL_DSEL1] == 2'b11) |-> g_clu[1].u_cell.d == link_from_above;
   endproperty
   a_above: assert property (p_above) else $error("link from above not used");

   property p_lut;
      @(posedge pclk) disable iff (!presetn)
         (ctrl_q[CTL_CSRC+1:CTL_CSRC] == 2'b00) |->
         comb_out[2] == lut_q[2][{comb_in[11:9],
                                  invertible_second_input[2] ^ ctrl_q[CTL_INV+2], comb_in[8]}];
   endproperty
   a_lut: assert property (p_lut) else $error("table lookup wrong");

   property p_inv;
      @(posedge pclk) disable iff (!presetn)
         (ctrl_q[CTL_INV] && ctrl_q[CTL_CSRC+1:CTL_CSRC] == 2'b00) |->
         comb_out[0] == lut_q[0][{comb_in[3:1], ~invertible_second_input[0], comb_in[0]}];
   endproperty
   a_inv: assert property (p_inv) else $error("inverter option ignored");

   property p_pin_ignored;
      @(posedge pclk) disable iff (!presetn)
         (ctrl_q[CTL_AINT] && $stable(ctrl_q) && $stable(comb_out[ROUTED_GLOBAL_CLOCK_A_CELL])) |-> $stable(clk_a_lvl);
   endproperty
   a_pin_ignored: assert property (p_pin_ignored) else $error("pin leaks into logic clock");

   property p_hard_sel;
      @(posedge pclk) disable iff (!presetn)
         (ctrl_q[CTL_CSEL0+1:CTL_CSEL0] == 2'b00) |-> g_clu[0].u_cell.clk_lvl == hard_clock;
   endproperty
   a_hard_sel: assert property (p_hard_sel) else $error("hard clock not selected");

   property p_top_src;
      @(posedge pclk) disable iff (!presetn)
         (ctrl_q[CTL_CSRC+1:CTL_CSRC] == 2'b10) |-> g_comb[3].idx[4] == clk_b_lvl;
   endproperty
   a_top_src: assert property (p_top_src) else $error("routed clock not at logic input");

   property p_wr_rd;
      @(posedge pclk) disable iff (!presetn)
         (wr_en && paddr == ADDR_CTRL) |=> ctrl_q == $past(pwdata[CTL_WIDTH-1:0]);
   endproperty
   a_wr_rd: assert property (p_wr_rd) else $error("control write lost");

   // ----------------------------------------
   // bus, clock net and link checks
   // ----------------------------------------
   // misaligned or out-of-range words are refused in the access phase
   property p_refuse;
      @(posedge pclk) disable iff (!presetn)
         (psel && penable && (paddr[1:0] != 2'b00 || paddr > ADDR_STATUS)) |-> pslverr;
   endproperty
   a_refuse: assert property (p_refuse) else $error("unmapped access not refused");

   property p_accept;
      @(posedge pclk) disable iff (!presetn)
         (psel && penable && paddr == ADDR_LUT0) |-> !pslverr;
   endproperty
   a_accept: assert property (p_accept) else $error("mapped access refused");

   // a refused write must not leak into the control word
   property p_refused_wr;
      @(posedge pclk) disable iff (!presetn)
         (psel && penable && pwrite && paddr > ADDR_STATUS) |=> $stable(ctrl_q);
   endproperty
   a_refused_wr: assert property (p_refused_wr) else $error("refused write changed control");

   // read word stands until the next read setup
   property p_rd_hold;
      @(posedge pclk) disable iff (!presetn)
         !rd_setup |=> $stable(prdata);
   endproperty
   a_rd_hold: assert property (p_rd_hold) else $error("read data moved outside setup");

   property p_lut_wr;
      @(posedge pclk) disable iff (!presetn)
         (wr_en && paddr == ADDR_LUT3) |=> lut_q[3] == $past(pwdata);
   endproperty
   a_lut_wr: assert property (p_lut_wr) else $error("table write lost");

   // a logic-sourced net follows its cell, the pin is ignored
   property p_routed_global_clock_a_logic;
      @(posedge pclk) disable iff (!presetn)
         ctrl_q[CTL_AINT] |-> clk_a_lvl == comb_out[ROUTED_GLOBAL_CLOCK_A_CELL];
   endproperty
   a_routed_global_clock_a_logic: assert property (p_routed_global_clock_a_logic) else $error("clock a not from logic");

   property p_routed_global_clock_a_pin;
      @(posedge pclk) disable iff (!presetn)
         !ctrl_q[CTL_AINT] |-> clk_a_lvl == routed_global_clock_a;
   endproperty
   a_routed_global_clock_a_pin: assert property (p_routed_global_clock_a_pin) else $error("clock a not from pin");

   property p_routed_global_clock_b_pin;
      @(posedge pclk) disable iff (!presetn)
         !ctrl_q[CTL_BINT] |-> clk_b_lvl == routed_global_clock_b;
   endproperty
   a_routed_global_clock_b_pin: assert property (p_routed_global_clock_b_pin) else $error("clock b not from pin");

   property p_cell_a;
      @(posedge pclk) disable iff (!presetn)
         (ctrl_q[CTL_CSEL1+1:CTL_CSEL1] == 2'b01) |-> g_clu[1].u_cell.clk_lvl == clk_a_lvl;
   endproperty
   a_cell_a: assert property (p_cell_a) else $error("register cell not on clock a");

   // the off setting must park the cell clock, or a stray edge could load it
   property p_off_low;
      @(posedge pclk) disable iff (!presetn)
         (ctrl_q[CTL_CSEL1+1:CTL_CSEL1] == 2'b11) |-> !g_clu[1].u_cell.clk_lvl;
   endproperty
   a_off_low: assert property (p_off_low) else $error("switched-off clock not parked");

   property p_pin_top;
      @(posedge pclk) disable iff (!presetn)
         (ctrl_q[CTL_CSRC+1:CTL_CSRC] == 2'b11) |-> g_comb[0].in4 == comb_in[3];
   endproperty
   a_pin_top: assert property (p_pin_top) else $error("top input not from pin");

   property p_pair;
      @(posedge pclk) disable iff (!presetn)
         (ctrl_q[CTL_DSEL0+1:CTL_DSEL0] == 2'b01) |-> g_clu[0].u_cell.d == comb_out[1];
   endproperty
   a_pair: assert property (p_pair) else $error("pair link not used");

   property p_below_reg;
      @(posedge pclk) disable iff (!presetn)
         (ctrl_q[CTL_BELOW+2:CTL_BELOW] == 3'h4) |-> link_to_below == reg_q[0];
   endproperty
   a_below_reg: assert property (p_below_reg) else $error("downward link not from register");

   property p_below_park;
      @(posedge pclk) disable iff (!presetn)
         (ctrl_q[CTL_BELOW+2:CTL_BELOW+1] == 2'b11) |-> !link_to_below;
   endproperty
   a_below_park: assert property (p_below_park) else $error("unused link code not parked");
endmodule : lcrcs_cluster_top
`default_nettype wire

// ===== dv/lcrcs_far_model.sv
`timescale 1ns/10ps
`default_nettype none
module lcrcs_far_model (
   input  wire logic       pclk,                  // bench clock
   input  wire logic       presetn,               // async reset, low
   input  wire logic [2:0] run,                   // hard, a, b running
   input  wire logic [2:0] park,                  // level of a stopped net
   output wire logic       hard_clock,            // dedicated clock net
   output wire logic       routed_global_clock_a, // clock a pin
   output wire logic       routed_global_clock_b  // clock b pin
);
   // ----------------------------------------
   // clock sources of the far side
   // ----------------------------------------
   logic [1:0] cnt_q;
   logic [2:0] ck_q;

   // each net is pclk over eight; a stopped pin sits at a fixed level, never floats
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_q <= 2'h0;
         ck_q  <= 3'h0;
      end else begin
         cnt_q <= cnt_q + 2'h1;
         for (int i = 0; i < 3; i++) begin
            if (!run[i]) ck_q[i] <= park[i];
            else if (cnt_q == 2'h3) ck_q[i] <= ~ck_q[i];
         end
      end
   end

   assign {routed_global_clock_b, routed_global_clock_a, hard_clock} = ck_q;
endmodule : lcrcs_far_model
`default_nettype wire

// ===== dv/tb.sv
`timescale 1ns/10ps
`default_nettype none
module tb
   import lcrcs_pkg::*;
;
   logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0]  paddr = 8'h00, below = 8'h35;
   logic [31:0] pwdata = 32'h0, prdata, rd, lut;
   logic        pready, pslverr, er, link_to_below, link_from_above = 1'b0;
   logic        hard_clock, routed_global_clock_a, routed_global_clock_b;
   logic [15:0] comb_in = 16'h0;
   logic [3:0]  invertible_second_input = 4'h0, comb_out;
   logic [1:0]  enable_select_line_0 = 2'h0, enable_select_line_1 = 2'h0;
   logic [1:0]  clear_n = 2'h3, preset_n = 2'h3, reg_q;
   logic [2:0]  run = 3'h0, park = 3'h0;
   int          errors = 0, samples_checked = 0;

   // 250 MHz clock
   initial begin
      forever #2 pclk = ~pclk;
   end

   lcrcs_cluster_top u_dut (
      .pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr,
      .hard_clock, .routed_global_clock_a, .routed_global_clock_b, .comb_in,
      .invertible_second_input, .enable_select_line_0, .enable_select_line_1, .clear_n,
      .preset_n, .link_from_above, .comb_out, .reg_q, .link_to_below
   );
   lcrcs_far_model u_far (
      .pclk, .presetn, .run, .park, .hard_clock, .routed_global_clock_a, .routed_global_clock_b
   );

   // ----------------------------------------
   // tasks
   // ----------------------------------------
   task automatic print_verdict;
      if (errors == 0 && samples_checked > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : print_verdict

   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
      samples_checked++;
      if (got !== exp) begin
         errors++;
         $display("[FAIL] %0t %s got %h exp %h", $time, msg, got, exp);
      end
   endtask : chk

   task automatic hang(input string msg);
      errors++;
      $display("[FAIL] %0t wait ran out: %s", $time, msg);
      print_verdict();
   endtask : hang

   // one apb transfer; request held until pready is seen high
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      for (n = 0; n < 20 && pready !== 1'b1; n++) @(posedge pclk);
      if (n == 20) hang("pready");
      rd = prdata;
      er = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask : apb

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask : wr

   // bounded wait for a register cell to take a value
   task automatic wait_q(input int b, input logic v);
      int n;
      for (n = 0; n < 40 && reg_q[b] !== v; n++) begin
         @(posedge pclk);
         #1;
      end
      if (n == 40) hang("register cell");
   endtask : wait_q

   task automatic cyc(input int n);
      repeat (n) @(posedge pclk);
      #1;
   endtask : cyc

   // ----------------------------------------
   // sequence
   // ----------------------------------------
   initial begin
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      apb(1'b0, ADDR_STATUS, 32'h0);
      chk(rd, 32'h0, "status after reset");
      wr(8'h18, 32'hffffffff);
      apb(1'b0, 8'h02, 32'h0);
      chk(er, 1'b1, "unmapped refused");
      apb(1'b0, ADDR_CTRL, 32'h0);
      chk(rd, 32'h0, "ctrl untouched");
      // every table index, with and without the second input inverted
      lut = 32'h9a3c5e71;
      wr(ADDR_LUT0, lut);
      for (int v = 0; v < 2; v++) begin
         wr(ADDR_CTRL, 32'(v) << CTL_INV);
         for (int i = 0; i < 32; i++) begin
            @(posedge pclk);
            comb_in[3:0] <= {i[4], i[3], i[2], i[0]};
            invertible_second_input[0] <= i[1];
            #1;
            chk(comb_out[0], lut[i ^ (v << 1)], "table output");
         end
      end
      comb_in <= 16'h0;
      // cell 0 on the hard clock, rising edge, data over the fixed wire
      wr(ADDR_LUT0, 32'hffffffff);
      wr(ADDR_CTRL, 32'h0);
      enable_select_line_0 <= 2'b01;
      run <= 3'b001;
      wait_q(0, 1'b1);
      chk(hard_clock, 1'b1, "rising capture");
      enable_select_line_0 <= 2'b00;
      wr(ADDR_LUT0, 32'hffff0000);
      cyc(24);
      chk(reg_q[0], 1'b1, "disabled cell holds");
      enable_select_line_1 <= 2'b01;
      wait_q(0, 1'b0);
      // hard clock never reaches the table, with the top input source on the pin or the reserved code
      for (int s = 0; s < 4; s += 3) begin
         wr(ADDR_CTRL, 32'(s) << CTL_CSRC);
         for (int k = 0; k < 12; k++) begin
            cyc(1);
            chk(comb_out[0], 1'b0, "hard clock kept out");
         end
      end
      // cell 1 on routed clock b, falling edge
      wr(ADDR_LUT0 + 8'h08, 32'hffffffff);
      wr(ADDR_CTRL, (32'(CS_B) << CTL_CSEL1) | (32'h1 << CTL_POL1));
      enable_select_line_0 <= 2'b10;
      run <= 3'b100;
      wait_q(1, 1'b1);
      chk(routed_global_clock_b, 1'b0, "falling capture");
      // routed clocks as table inputs
      for (int s = 1; s < 3; s++) begin
         wr(ADDR_CTRL, 32'(s) << CTL_CSRC);
         for (int l = 0; l < 2; l++) begin
            run <= 3'b000;
            park <= {l[0], l[0], 1'b0};
            cyc(4);
            chk(comb_out[0], l[0], "routed clock into table");
         end
      end
      // clock a made by logic while its pin is parked low
      park <= 3'b000;
      wr(ADDR_LUT0 + 8'h08, 32'h0);
      wr(ADDR_CTRL, (32'(CS_A) << CTL_CSEL1) | (32'h1 << CTL_AINT));
      cyc(8);
      chk(reg_q[1], 1'b1, "no edge from a still source");
      wr(ADDR_LUT0 + 8'h04, 32'hffffffff);
      wait_q(1, 1'b0);
      // asynchronous preset and clear, clear winning
      enable_select_line_0 <= 2'b00;
      enable_select_line_1 <= 2'b00;
      for (int k = 0; k < 5; k++) begin
         @(posedge pclk);
         clear_n  <= (k == 1) ? 2'b00 : 2'b11;
         preset_n <= (k == 2 || k == 3) ? 2'b11 : 2'b00;
         #1;
         chk(reg_q, (k >= 1 && k <= 3) ? 2'b00 : 2'b11, "clear and preset");
      end
      @(posedge pclk);
      preset_n <= 2'b11;
      cyc(8);
      chk(reg_q, 2'b11, "state held after release");
      // each cell its own table; downward link selects every source
      for (int g = 0; g < 4; g++)
         wr(ADDR_LUT0 + 8'(4 * g), g[0] ? 32'h0 : 32'hffffffff);
      chk(comb_out, 4'b0101, "four tables");
      for (int s = 0; s < 8; s++) begin
         wr(ADDR_CTRL, 32'(s) << CTL_BELOW);
         chk(link_to_below, below[s], "downward link");
      end
      // every data source of cell 0; cell 1 with its clock switched off
      enable_select_line_0 <= 2'b11;
      run <= 3'b111;
      for (int s = 0; s < 4; s++) begin
         wr(ADDR_CTRL, (32'(s) << CTL_DSEL0) | (32'(CS_OFF) << CTL_CSEL1) | (32'(DS_ABOVE) << CTL_DSEL1));
         wait_q(0, ~s[0]);
      end
      chk(reg_q[1], 1'b1, "switched-off clock holds");
      link_from_above <= 1'b1;
      wr(ADDR_CTRL, 32'(DS_ABOVE) << CTL_DSEL0);
      wait_q(0, 1'b1);
      print_verdict();
   end
endmodule : tb
`default_nettype wire
